// ===== enc_pos_pkg.sv
// shared constants, register map and types for the encoder position counter
package enc_pos_pkg;

  // bus and data widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PIN_N = 8;
  localparam int unsigned SEL_W = 3;

  // timebase: the block counts on its own bus clock
  localparam int unsigned TIMEBASE_HZ = 40_000_000;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CONFIG_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] PRESET_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] INDEX_VAL_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] SAMPLE_DATA_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h18;

  // control and status bit positions
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_STOP_BIT = 1;
  localparam int unsigned STAT_EMPTY_BIT = 2;
  localparam int unsigned STAT_FULL_BIT = 3;
  localparam int unsigned STAT_OVF_BIT = 4;
  localparam int unsigned STAT_LVL_LSB = 8;

  // reset values
  localparam logic [DATA_W-1:0] PRESET_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] INDEX_VAL_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CONFIG_RST = 32'h0000_0003;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ONE_WORD = 32'h0000_0001;

  // decoding types
  typedef enum logic [1:0] {
    DEC_TWO_PULSE = 2'b00,
    DEC_X1 = 2'b01,
    DEC_X2 = 2'b10,
    DEC_X4 = 2'b11
  } decode_t;

  // counter run states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;

  // configuration word, laid out exactly as the config register
  typedef struct packed {
    logic [PIN_N-1:0] filt_en;
    logic [SEL_W-1:0] samp_sel;
    logic [SEL_W-1:0] arm_sel;
    logic [SEL_W-1:0] z_sel;
    logic [SEL_W-1:0] b_sel;
    logic [SEL_W-1:0] a_sel;
    logic samp_fall;
    logic arm_fall;
    logic arm_en;
    logic samp_mode;
    logic [1:0] idx_phase;
    logic idx_en;
    decode_t decode;
  } cfg_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

endpackage

// ===== encoder_position_counter.sv
// quadrature / two-pulse encoder position counter with apb registers
//
// How it works
// R1 - quadrature: a leading b counts up
// R2 - quadrature: b leading a counts down
// R3 - x1: up on a rise, down on fall
// R4 - x2: step on both a edges
// R5 - x4: step on every a and b edge
// R6 - index high in chosen phase reloads count
// R7 - a count step wins over reload
// R8 - reload done within one timebase period
// R9 - encoder holds index high in reload phase
// R10 - two-pulse: a rise up, b rise down
// R11 - decoding type selectable, four kinds
// R12 - index enable, phase and value settable
// R13 - preset loaded before counting begins
// R14 - on demand: start counts, reads live count
// R15 - sample clock edge pushes count into buffer
// R16 - arm trigger edge starts counting instead
// R17 - a, b, index sources independently selectable
// R18 - optional noise filter per input pin
// R19 - timebase is the internal clock
// R20 - inputs synced, simultaneous a/b change ignored in x1, x2 and x4
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module encoder_position_counter
  import enc_pos_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned FILTER_LEN = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PIN_N-1:0] programmable_function_input,
  output logic counting
);

  localparam int unsigned AW = $clog2(FIFO_DEPTH);
  localparam int unsigned FW = $clog2(FILTER_LEN + 1);
  localparam logic [FW-1:0] FILT_LAST = FW'(FILTER_LEN - 1);
  localparam logic [AW:0] LVL_FULL = (AW+1)'(FIFO_DEPTH);

  // the whole state of the block in one word
  typedef struct packed {
    run_state_t st;
    cfg_t cfg;
    logic [DATA_W-1:0] preset;
    logic [DATA_W-1:0] idx_val;
    logic [DATA_W-1:0] count;
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    logic [PIN_N-1:0] filt;
    logic [PIN_N-1:0][FW-1:0] fcnt;
    logic a_q;
    logic b_q;
    logic arm_q;
    logic samp_q;
    logic reload_done;
    logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] lvl;
    logic ovf;
    logic [DATA_W-1:0] rdata;
    logic rd_live;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // per-pin filter next values, built in the generate loop below
  logic [PIN_N-1:0] filt_nxt;
  logic [PIN_N-1:0][FW-1:0] fcnt_nxt;

  // a filtered pin only follows its input after it has held steady
  // for FILTER_LEN cycles; this trades latency for glitch immunity
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_filt
      always_comb begin
        filt_nxt[gi] = s_r.filt[gi];
        fcnt_nxt[gi] = '0;
        if (!s_r.cfg.filt_en[gi]) begin
          filt_nxt[gi] = s_r.sync2[gi]; // R18
        end else if (s_r.sync2[gi] != s_r.filt[gi]) begin
          if (s_r.fcnt[gi] == FILT_LAST) begin
            filt_nxt[gi] = s_r.sync2[gi]; // R18
          end else begin
            fcnt_nxt[gi] = s_r.fcnt[gi] + FW'(1);
          end
        end
      end
    end
  endgenerate

  // selected encoder, trigger and sample signals
  logic a_in;
  logic b_in;
  logic z_in;
  logic arm_in;
  logic samp_in;
  assign a_in = s_r.filt[s_r.cfg.a_sel]; // R17
  assign b_in = s_r.filt[s_r.cfg.b_sel]; // R17
  assign z_in = s_r.filt[s_r.cfg.z_sel]; // R17
  assign arm_in = s_r.filt[s_r.cfg.arm_sel];
  assign samp_in = s_r.filt[s_r.cfg.samp_sel];

  // apb phases; the slave never inserts wait states
  logic setup_ph;
  logic access_ph;
  logic addr_ok;
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access_ph && !addr_ok;
  assign prdata = s_r.rdata;
  assign counting = (s_r.st == ST_RUN);

  always_comb begin
    addr_ok = 1'b0;
    if (paddr == CTRL_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == CONFIG_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == PRESET_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == INDEX_VAL_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == COUNT_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == SAMPLE_DATA_OFS) begin
      addr_ok = 1'b1;
    end else if (paddr == STATUS_OFS) begin
      addr_ok = 1'b1;
    end
  end

  // edge and step decode
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic both_chg;
  logic step_up;
  logic step_dn;
  logic in_phase;
  logic arm_edge;
  logic samp_edge;
  logic wr;
  logic start_cmd;
  logic stop_cmd;
  logic pop;
  logic push;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] status_word;

  always_comb begin
    a_rise = a_in && !s_r.a_q;
    a_fall = !a_in && s_r.a_q;
    b_rise = b_in && !s_r.b_q;
    b_fall = !b_in && s_r.b_q;
    // a and b moving in the same sample carries no direction
    both_chg = (a_rise || a_fall) && (b_rise || b_fall); // R20
    step_up = 1'b0;
    step_dn = 1'b0;
    case (s_r.cfg.decode)
      DEC_TWO_PULSE: begin
        // both rising together would net to zero anyway
        step_up = a_rise && !b_rise; // R10
        step_dn = b_rise && !a_rise; // R10
      end
      DEC_X1: begin
        if (!both_chg) begin
          step_up = a_rise && !b_in; // R1 R3
          step_dn = a_fall && !b_in; // R2 R3
        end
      end
      DEC_X2: begin
        if (!both_chg) begin
          step_up = (a_rise && !b_in) || (a_fall && b_in); // R1 R4
          step_dn = (a_rise && b_in) || (a_fall && !b_in); // R2 R4
        end
      end
      default: begin
        if (!both_chg) begin
          step_up = (a_rise && !b_in) || (a_fall && b_in) ||
                    (b_rise && a_in) || (b_fall && !a_in); // R1 R5
          step_dn = (a_rise && b_in) || (a_fall && !b_in) ||
                    (b_rise && !a_in) || (b_fall && a_in); // R2 R5
        end
      end
    endcase
    // reload phase is the {a,b} level pair chosen in idx_phase
    in_phase = ({a_in, b_in} == s_r.cfg.idx_phase); // R6
    arm_edge = s_r.cfg.arm_fall ? (!arm_in && s_r.arm_q)
                                : (arm_in && !s_r.arm_q); // R16
    samp_edge = s_r.cfg.samp_fall ? (!samp_in && s_r.samp_q)
                                  : (samp_in && !s_r.samp_q);
    wr = access_ph && pwrite;
    start_cmd = wr && (paddr == CTRL_OFS) && pwdata[CTRL_START_BIT];
    stop_cmd = wr && (paddr == CTRL_OFS) && pwdata[CTRL_STOP_BIT];
    // pop only what the setup cycle handed out, so a sample pushed
    // between setup and access is not thrown away unread
    pop = access_ph && !pwrite && (paddr == SAMPLE_DATA_OFS) &&
          s_r.rd_live; // R15
    push = (s_r.st == ST_RUN) && s_r.cfg.samp_mode && samp_edge; // R15
  end

  // read data is captured in the setup cycle so prdata is a flop
  always_comb begin
    status_word = ZERO_WORD;
    status_word[1:0] = s_r.st;
    status_word[STAT_EMPTY_BIT] = (s_r.lvl == '0);
    status_word[STAT_FULL_BIT] = (s_r.lvl == LVL_FULL);
    status_word[STAT_OVF_BIT] = s_r.ovf;
    status_word[STAT_LVL_LSB +: AW+1] = s_r.lvl;
    rd_word = ZERO_WORD;
    if (paddr == CONFIG_OFS) begin
      rd_word = s_r.cfg;
    end else if (paddr == PRESET_OFS) begin
      rd_word = s_r.preset;
    end else if (paddr == INDEX_VAL_OFS) begin
      rd_word = s_r.idx_val;
    end else if (paddr == COUNT_OFS) begin
      rd_word = s_r.count; // R14
    end else if (paddr == SAMPLE_DATA_OFS) begin
      rd_word = (s_r.lvl != '0) ? s_r.mem[s_r.rp] : ZERO_WORD; // R15
    end else if (paddr == STATUS_OFS) begin
      rd_word = status_word;
    end
  end

  // next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    // two-stage synchroniser then filter
    s_nxt.sync1 = programmable_function_input; // R20
    s_nxt.sync2 = s_r.sync1; // R20
    s_nxt.filt = filt_nxt;
    s_nxt.fcnt = fcnt_nxt;
    s_nxt.a_q = a_in;
    s_nxt.b_q = b_in;
    s_nxt.arm_q = arm_in;
    s_nxt.samp_q = samp_in;
    if (setup_ph) begin
      s_nxt.rdata = rd_word;
      s_nxt.rd_live = (s_r.lvl != '0);
    end
    // register writes
    if (wr && (paddr == CONFIG_OFS)) begin
      s_nxt.cfg = cfg_t'(pwdata); // R11 R12
    end
    if (wr && (paddr == PRESET_OFS)) begin
      s_nxt.preset = pwdata;
    end
    if (wr && (paddr == INDEX_VAL_OFS)) begin
      s_nxt.idx_val = pwdata; // R12
    end
    // run control
    case (s_r.st)
      ST_IDLE: begin
        if (start_cmd) begin
          s_nxt.count = s_r.preset; // R13
          s_nxt.reload_done = 1'b0;
          s_nxt.st = s_r.cfg.arm_en ? ST_ARMED : ST_RUN; // R14 R16
        end
      end
      ST_ARMED: begin
        if (stop_cmd) begin
          s_nxt.st = ST_IDLE;
        end else if (arm_edge) begin
          s_nxt.st = ST_RUN; // R16
        end
      end
      ST_RUN: begin
        if (stop_cmd) begin
          s_nxt.st = ST_IDLE;
        end
        // a step always lands first; a reload waits for a step-free
        // cycle, which is the next one, so it is at most one period late
        if (step_up) begin
          s_nxt.count = s_r.count + ONE_WORD; // R1 R7
        end else if (step_dn) begin
          s_nxt.count = s_r.count - ONE_WORD; // R2 R7
        end else if (s_r.cfg.idx_en && z_in && in_phase &&
                     !s_r.reload_done) begin
          s_nxt.count = s_r.idx_val; // R6 R8 R9 R12
          s_nxt.reload_done = 1'b1;
        end
        // one reload per visit to the phase, then counting resumes
        if (!in_phase) begin
          s_nxt.reload_done = 1'b0; // R8
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // sample buffer; a push into a full buffer is lost and flagged
    if (push && (s_r.lvl != LVL_FULL || pop)) begin
      s_nxt.mem[s_r.wp] = s_r.count; // R15
      s_nxt.wp = s_r.wp + AW'(1);
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + AW'(1);
    end
    if (push && !pop && (s_r.lvl != LVL_FULL)) begin
      s_nxt.lvl = s_r.lvl + (AW+1)'(1);
    end else if (pop && !push) begin
      s_nxt.lvl = s_r.lvl - (AW+1)'(1);
    end
    // overflow is write-one-to-clear; a new overflow wins the race
    if (wr && (paddr == STATUS_OFS) && pwdata[STAT_OVF_BIT]) begin
      s_nxt.ovf = 1'b0;
    end
    if (push && !pop && (s_r.lvl == LVL_FULL)) begin
      s_nxt.ovf = 1'b1;
    end
    // starting afresh empties the buffer of an earlier run
    if ((s_r.st == ST_IDLE) && start_cmd) begin
      s_nxt.wp = '0;
      s_nxt.rp = '0;
      s_nxt.lvl = '0;
    end
  end

  // everything runs on the internal bus clock as its timebase
  always_ff @(posedge pclk or negedge presetn) begin // R19
    if (!presetn) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.cfg <= cfg_t'(CONFIG_RST);
      s_r.preset <= PRESET_RST;
      s_r.idx_val <= INDEX_VAL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

`default_nettype wire

// ===== encoder_position_counter_monitor.sv
// port-level assertions for the encoder position counter
`timescale 1ns/1ps
`default_nettype none
module encoder_position_counter_monitor
  import enc_pos_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic counting
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic acc;
  logic bad_adr;
  logic arm_on_r;
  // access phase and address decode seen from the bus
  assign acc = psel & penable;
  assign bad_adr = (paddr > STATUS_OFS) || (paddr[1:0] != 2'b00);

  // shadow of the arm enable, since the config is not visible here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_on_r <= 1'b0;
    end else if (acc && pwrite && paddr == CONFIG_OFS) begin
      arm_on_r <= pwdata[6];
    end
  end

  sequence ctrl_wr;
    acc && pwrite && paddr == CTRL_OFS;
  endsequence
  sequence start_cmd;
    ctrl_wr ##0 (pwdata[0] && !pwdata[1] && !counting);
  endsequence

  pready_high_a: assert property (pready)
    else $error("pready dropped");
  slverr_map_a: assert property (acc |-> pslverr == bad_adr)
    else $error("slave error does not match decode");
  slverr_idle_a: assert property (!acc |-> !pslverr)
    else $error("slave error outside access");
  bad_read_zero_a: assert property (acc && !pwrite && bad_adr |->
    prdata == ZERO_WORD) else $error("unmapped read not zero");
  ctrl_read_zero_a: assert property (acc && !pwrite && paddr == CTRL_OFS
    |-> prdata == ZERO_WORD) else $error("control read not zero");
  start_run_a: assert property (start_cmd ##0 !arm_on_r |=> counting)
    else $error("start did not run");
  arm_wait_a: assert property (start_cmd ##0 arm_on_r |=> !counting)
    else $error("armed start ran at once");
  stop_idle_a: assert property (ctrl_wr ##0 (pwdata[1] && !pwdata[0])
    |=> !counting [*2]) else $error("stop did not halt");
  run_cause_a: assert property ($rose(counting) |-> arm_on_r ||
    $past(acc && pwrite && paddr == CTRL_OFS)) else $error("run without cause");
endmodule
`default_nettype wire

// ===== encoder_model.sv
// behavioural quadrature and two-pulse encoder with index line
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
  input wire logic clk,
  output logic a,
  output logic b,
  output logic z
);
  logic [1:0] ph;
  // phase order 00,10,11,01: stepping forward puts a ahead of b
  initial begin
    a = 1'b0;
    b = 1'b0;
    z = 1'b0;
    ph = 2'b00;
  end
  // hold sets how slowly the shaft turns
  task quad(input logic up, input int n, input int hold);
    repeat (n) begin
      @(posedge clk);
      ph = up ? ph + 2'd1 : ph - 2'd1;
      a <= ph[0] ^ ph[1];
      b <= ph[1];
      repeat (hold) @(posedge clk);
    end
  endtask
  // two-pulse: a for forward, b for reverse, idle low
  task pulses(input logic on_b, input int n, input int hold);
    repeat (n) begin
      @(posedge clk);
      if (on_b) b <= 1'b1;
      else a <= 1'b1;
      repeat (hold) @(posedge clk);
      a <= 1'b0;
      b <= 1'b0;
      repeat (hold) @(posedge clk);
    end
  endtask
  // faulty jump: both lines flip together, only when commanded
  task jump;
    @(posedge clk);
    ph = ph + 2'd2;
    a <= ~a;
    b <= ~b;
    repeat (4) @(posedge clk);
  endtask
  // index level held across the whole reload phase
  task mark(input logic v);
    @(posedge clk);
    z <= v;
  endtask
endmodule
`default_nettype wire

// ===== encoder_position_counter_tb.sv
// self-checking bench for the encoder position counter
`timescale 1ns/1ps
`default_nettype none
module encoder_position_counter_tb import enc_pos_pkg::*;;
  // a=pin0 b=pin1 index=pin2 arm=pin3 sample=pin4, filters off
  localparam logic [31:0] CFG_BASE = 32'h008D_1000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, counting;
  logic arm, smp, a, b, z, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [PIN_N-1:0] pins;
  int bad_count, checks;
  assign pins = {3'b000, smp, arm, z, b, a};

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  encoder_position_counter u_encoder_position_counter (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .programmable_function_input(pins),
    .counting(counting));
  encoder_model u_encoder_model (.clk(pclk), .a(a), .b(b), .z(z));

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one apb transfer; waits for pready, bounded
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input string what, input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, ZERO_WORD);
    chk(what, e, rd);
  endtask
  task runchk(input logic e);
    @(negedge pclk);
    chk("counting", 32'(e), 32'(counting));
  endtask
  task settle;
    repeat (8) @(posedge pclk);
  endtask
  // pulse the sample or arm pin
  task trig(input logic s);
    @(posedge pclk);
    if (s) smp <= 1'b1;
    else arm <= 1'b1;
    repeat (4) @(posedge pclk);
    smp <= 1'b0;
    arm <= 1'b0;
    settle();
  endtask

  task t_regs;
    rdchk("config", CONFIG_OFS, CONFIG_RST);
    rdchk("preset", PRESET_OFS, PRESET_RST);
    rdchk("unmapped", 8'h1C, ZERO_WORD);
    chk("slave error", ONE_WORD, 32'(err));
    apb(1'b1, INDEX_VAL_OFS, 32'h0000_5A5A);
    rdchk("index value", INDEX_VAL_OFS, 32'h0000_5A5A);
    apb(1'b1, COUNT_OFS, 32'hFFFF_FFFF);
    rdchk("count read only", COUNT_OFS, ZERO_WORD);
  endtask
  // every decode type: one cycle forward, two back (slow)
  task t_decode;
    logic [31:0] k;
    for (int m = 0; m < 4; m++) begin
      k = (m == 1) ? 32'h0000_0001 : (m == 2) ? 32'h0000_0002 : 32'h0000_0004;
      apb(1'b1, CONFIG_OFS, CFG_BASE | 32'(m));
      apb(1'b1, PRESET_OFS, 32'h0000_1000);
      apb(1'b1, CTRL_OFS, ONE_WORD);
      runchk(1'b1);
      rdchk("preset load", COUNT_OFS, 32'h0000_1000);
      if (m == 0) u_encoder_model.pulses(1'b0, 4, 2);
      else u_encoder_model.quad(1'b1, 4, 2);
      settle();
      rdchk("count up", COUNT_OFS, 32'h0000_1000 + k);
      if (m == 3) begin
        u_encoder_model.jump();
        rdchk("jump ignored", COUNT_OFS, 32'h0000_1000 + k);
        u_encoder_model.jump();
      end
      if (m == 0) u_encoder_model.pulses(1'b1, 8, 6);
      else u_encoder_model.quad(1'b0, 8, 6);
      settle();
      rdchk("count down", COUNT_OFS, 32'h0000_1000 - k);
      apb(1'b1, CTRL_OFS, 32'h0000_0002);
    end
  endtask
  // two-pulse with a and b sources swapped and pins 0, 1 filtered:
  // a one-cycle glitch must vanish, long pulses on pin 0 count down
  task t_filter;
    apb(1'b1, CONFIG_OFS, 32'h038D_0200);
    apb(1'b1, PRESET_OFS, ZERO_WORD);
    apb(1'b1, CTRL_OFS, ONE_WORD);
    u_encoder_model.pulses(1'b0, 1, 1);
    settle();
    rdchk("glitch filtered", COUNT_OFS, ZERO_WORD);
    u_encoder_model.pulses(1'b0, 2, 6);
    settle();
    rdchk("swapped filtered", COUNT_OFS, 32'hFFFF_FFFE);
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
  endtask
  task t_index;
    apb(1'b1, CONFIG_OFS, CFG_BASE | 32'h0000_0007);
    apb(1'b1, INDEX_VAL_OFS, 32'h0000_0100);
    apb(1'b1, PRESET_OFS, ZERO_WORD);
    apb(1'b1, CTRL_OFS, ONE_WORD);
    u_encoder_model.quad(1'b1, 1, 2);
    u_encoder_model.mark(1'b1);
    u_encoder_model.quad(1'b1, 3, 2);
    settle();
    rdchk("reload", COUNT_OFS, 32'h0000_0100);
    u_encoder_model.mark(1'b0);
    u_encoder_model.quad(1'b1, 4, 2);
    settle();
    rdchk("no index", COUNT_OFS, 32'h0000_0104);
    apb(1'b1, CONFIG_OFS, CFG_BASE | 32'h0000_0003);
    u_encoder_model.mark(1'b1);
    u_encoder_model.quad(1'b1, 4, 2);
    settle();
    rdchk("index off", COUNT_OFS, 32'h0000_0108);
    u_encoder_model.mark(1'b0);
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
  endtask
  task t_arm;
    apb(1'b1, CONFIG_OFS, CFG_BASE | 32'h0000_0043);
    apb(1'b1, PRESET_OFS, ZERO_WORD);
    apb(1'b1, CTRL_OFS, ONE_WORD);
    runchk(1'b0);
    u_encoder_model.quad(1'b1, 4, 2);
    settle();
    rdchk("armed count", COUNT_OFS, ZERO_WORD);
    trig(1'b0);
    runchk(1'b1);
    u_encoder_model.quad(1'b1, 4, 2);
    settle();
    rdchk("run count", COUNT_OFS, 32'h0000_0004);
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
  endtask
  task t_sample;
    apb(1'b1, CONFIG_OFS, CFG_BASE | 32'h0000_0023);
    apb(1'b1, PRESET_OFS, 32'h0000_0010);
    apb(1'b1, CTRL_OFS, ONE_WORD);
    rdchk("empty", SAMPLE_DATA_OFS, ZERO_WORD);
    trig(1'b1);
    u_encoder_model.quad(1'b1, 2, 2);
    settle();
    trig(1'b1);
    rdchk("status two", STATUS_OFS, 32'h0000_0202);
    rdchk("sample one", SAMPLE_DATA_OFS, 32'h0000_0010);
    rdchk("sample two", SAMPLE_DATA_OFS, 32'h0000_0012);
    rdchk("drained", SAMPLE_DATA_OFS, ZERO_WORD);
    rdchk("status empty", STATUS_OFS, 32'h0000_0006);
    // sixteen samples fill the buffer, the seventeenth overflows
    repeat (17) trig(1'b1);
    rdchk("status overflow", STATUS_OFS, 32'h0000_101A);
    apb(1'b1, STATUS_OFS, 32'h0000_0010);
    rdchk("overflow cleared", STATUS_OFS, 32'h0000_100A);
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
  endtask

  // main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    arm = 1'b0;
    smp = 1'b0;
    presetn = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_decode();
    t_filter();
    t_index();
    t_arm();
    t_sample();
    print_verdict();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end
endmodule

bind encoder_position_counter encoder_position_counter_monitor
  u_encoder_position_counter_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .counting(counting));
`default_nettype wire
